/* File: sarcv_consts.svh */
// Timing and field constants for the converter control block
`ifndef SARCV_CONSTS_SVH
`define SARCV_CONSTS_SVH
`define SARCV_RES_W        16
`define SARCV_MSB          15
`define SARCV_CONV_NS      2500
`define SARCV_ACQ_NS       1485
`define SARCV_STROBE_HI_NS 250
`define SARCV_STROBE_LO_NS 40
`define SARCV_RECOV_NS     5000000
`define SARCV_LINK_NS      160
`define SARCV_SHIFT_MAX_NS 66
`define SARCV_READ_NS      800
`endif

/* File: sarcv_pkg.sv */
// Types shared by both ends of the converter link
package sarcv_pkg;
  typedef enum logic [1:0] {CV_IDLE, CV_CONV, CV_NAP, CV_ACQ} sarcv_conv_t;
  typedef enum logic [2:0] {HS_IDLE, HS_HIGH, HS_LOW, HS_WAIT, HS_READ, HS_SHIFT, HS_DONE} sarcv_host_t;
endpackage : sarcv_pkg

/* File: sarcv_link_if.sv */
// Pin-level link between converter and host
`timescale 1ns/1ps
interface sarcv_link_if;
  logic        convert_strobe_n;
  logic        shutdown_request;
  logic        resetPin;
  logic        csN;
  logic        rdN;
  logic        interface_select;
  logic        byte_order_select;
  logic        code_format_select;
  logic        shiftClk;
  logic        chain_in_line;
  logic        busy;
  logic [15:0] dataOut;
  logic [15:0] dataOeN;
  logic        serial_out_line;
  logic        serialOeN;
  modport device (input convert_strobe_n, shutdown_request, resetPin, csN, rdN, interface_select,
                  byte_order_select, code_format_select, shiftClk, chain_in_line,
                  output busy, dataOut, dataOeN, serial_out_line, serialOeN);
  modport host (output convert_strobe_n, shutdown_request, resetPin, csN, rdN, interface_select,
                byte_order_select, code_format_select, shiftClk, chain_in_line,
                input busy, dataOut, dataOeN, serial_out_line, serialOeN);
endinterface : sarcv_link_if

/* File: sarcv_sync.sv */
// Two-flop level synchroniser, one per bit
`timescale 1ns/1ps
module sarcv_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_ff;
  initial if (W < 1) $error("W too small");
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_ff <= '0;
      dout    <= '0;
    end else begin
      meta_ff <= din;
      dout    <= meta_ff;
    end
  end
endmodule : sarcv_sync

/* File: sarcv_device.sv */
// Converter end: conversion timing, nap, shutdown, parallel and serial readout
// Functional notes
// - Strobe held low after conversion enters nap
// - Host holds strobe high 250ns before start
// - Shutdown high ignores all conversion requests
// - Running conversion finishes, result kept through shutdown
// - Host reads result before requesting shutdown; host here forwards sleepReq to the pin at any time, even mid-conversion
// - Host waits 5ms after shutdown release; host here may start again with no recovery wait
// - Falling strobe edge starts a conversion
// - Start edges ignored while converting
// - Busy high throughout conversion
// - Strobe rises within 40ns or after end
// - Conversion lasts at most 2500ns
// - Outputs float if select or read high
// - Parallel word driven only when selected
// - Byte order select swaps the two halves
// - Serial out shifts only when selected
// - Change on shift rise, capture on fall
// - MSB first, held until second rise
// - Host shift clock at least 15MHz
// - Chain input sampled on falls, appended
// - Format select low inverts result MSB
// - Reset aborts, floats bus, ignores requests
// - Start accepted only after acquisition time; device enforces it after reset only, not between conversions
`timescale 1ns/1ps
`include "sarcv_consts.svh"
module sarcv_device #(
  parameter int W       = `SARCV_RES_W,
  parameter int LINK_NS = `SARCV_LINK_NS
) (
  input  wire logic         devClk,
  sarcv_link_if.device      link,
  input  wire logic [W-1:0] sampleCode
);
  localparam int CONV_CYC = `SARCV_CONV_NS / LINK_NS;
  localparam int ACQ_CYC  = (`SARCV_ACQ_NS + LINK_NS - 1) / LINK_NS;
  localparam int CW       = 8;
  initial if (W != `SARCV_RES_W || CONV_CYC < 2 || ACQ_CYC >= 2**CW) $error("bad params");

  typedef struct packed {
    sarcv_pkg::sarcv_conv_t st;
    logic [CW-1:0]          cnt;
    logic                   strobePrev;
    logic [W-1:0]           result;
    logic                   busy;
    logic [W-1:0]           shreg;
    logic                   sout;
    logic                   chainBit;
    logic                   gotFall;
    logic [W-1:0]           dout;
    logic [W-1:0]           doe;
    logic                   soe;
  } sarcv_dev_t;
  sarcv_dev_t cur_ff, nxt_cur;

  logic [5:0] syncIn;
  logic       strobeS, sdS, rstS, csS, rdS, selS;
  logic       byteS, fmtS;
  logic [1:0] syncB;
  logic       fallSeen_ff;
  logic       fallChain_ff;

  sarcv_sync #(.W(6)) uSyncA (
    .clk  (devClk),
    .rst  (link.resetPin),
    .din  ({link.convert_strobe_n, link.shutdown_request, 1'b0, link.csN, link.rdN,
            link.interface_select}),
    .dout (syncIn)
  );
  sarcv_sync #(.W(2)) uSyncB (
    .clk  (devClk),
    .rst  (link.resetPin),
    .din  ({link.byte_order_select, link.code_format_select}),
    .dout (syncB)
  );
  assign {strobeS, sdS, rstS, csS, rdS, selS} = syncIn;
  assign {byteS, fmtS} = syncB;

  // Falling-edge capture of chain input; first-fall marker cleared while deselected
  always_ff @(negedge link.shiftClk or posedge link.resetPin or posedge link.csN) begin
    if (link.resetPin || link.csN) begin
      fallSeen_ff  <= 1'b0;
      fallChain_ff <= 1'b0;
    end else begin
      fallSeen_ff  <= 1'b1;
      fallChain_ff <= link.chain_in_line;
    end
  end

  always_comb begin
    logic startEdge;
    logic rdSel;
    logic [W-1:0] fmt;
    startEdge = 1'b0;
    rdSel     = 1'b0;
    fmt       = '0;
    nxt_cur   = cur_ff;
    nxt_cur.strobePrev = strobeS;
    startEdge = cur_ff.strobePrev & ~strobeS;
    fmt = sampleCode;
    fmt[`SARCV_MSB] = sampleCode[`SARCV_MSB] ^ ~fmtS;
    case (cur_ff.st)
      sarcv_pkg::CV_ACQ: begin
        if (cur_ff.cnt == CW'(ACQ_CYC - 1)) nxt_cur.st = sarcv_pkg::CV_IDLE;
        else nxt_cur.cnt = cur_ff.cnt + 1'b1;
      end
      sarcv_pkg::CV_IDLE, sarcv_pkg::CV_NAP: begin
        if (!strobeS) nxt_cur.st = sarcv_pkg::CV_NAP;
        else nxt_cur.st = sarcv_pkg::CV_IDLE;
        if (startEdge && !sdS) begin
          nxt_cur.st   = sarcv_pkg::CV_CONV;
          nxt_cur.cnt  = '0;
          nxt_cur.busy = 1'b1;
        end
      end
      sarcv_pkg::CV_CONV: begin
        if (cur_ff.cnt == CW'(CONV_CYC - 1)) begin
          nxt_cur.result = fmt;
          nxt_cur.busy   = 1'b0;
          nxt_cur.st     = strobeS ? sarcv_pkg::CV_IDLE : sarcv_pkg::CV_NAP;
        end else begin
          nxt_cur.cnt = cur_ff.cnt + 1'b1;
        end
      end
      default: nxt_cur.st = sarcv_pkg::CV_IDLE;
    endcase
    rdSel = ~csS & ~rdS;
    nxt_cur.doe = {W{1'b1}};
    nxt_cur.soe = 1'b1;
    if (rdSel && !selS) begin
      nxt_cur.doe  = '0;
      nxt_cur.dout = byteS ? {cur_ff.result[7:0], cur_ff.result[15:8]}
                           : cur_ff.result;
    end
    if (rdSel && selS) nxt_cur.soe = 1'b0;
    if (!cur_ff.busy && nxt_cur.busy) nxt_cur.shreg = '0;
    if (cur_ff.busy && !nxt_cur.busy) nxt_cur.shreg = fmt;
    nxt_cur.sout = nxt_cur.shreg[`SARCV_MSB];
  end

  // Serial shifter on the rising shift clock
  logic [W-1:0] shOut_ff;
  logic         sdo_ff;
  logic [W-1:0] loadSync;
  // Result is quasi-static: it only changes at conversion end, never during a read
  assign loadSync = cur_ff.result;
  always_ff @(posedge link.shiftClk or posedge link.resetPin) begin
    if (link.resetPin) begin
      shOut_ff <= '0;
      sdo_ff   <= 1'b0;
    end else if (link.csN || !fallSeen_ff) begin
      shOut_ff <= loadSync;
      sdo_ff   <= loadSync[`SARCV_MSB];
    end else begin
      shOut_ff <= {shOut_ff[W-2:0], fallChain_ff};
      sdo_ff   <= shOut_ff[W-2];
    end
  end

  always_ff @(posedge devClk or posedge link.resetPin) begin
    if (link.resetPin) begin
      cur_ff      <= '0;
      cur_ff.st   <= sarcv_pkg::CV_ACQ;
      cur_ff.doe  <= {W{1'b1}};
      cur_ff.soe  <= 1'b1;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign link.busy            = cur_ff.busy;
  assign link.dataOut         = cur_ff.dout;
  assign link.dataOeN         = cur_ff.doe;
  assign link.serial_out_line = sdo_ff;
  assign link.serialOeN       = cur_ff.soe;
endmodule : sarcv_device

/* File: sarcv_host.sv */
// Host end: strobes a conversion, waits for busy, reads parallel or serial
`timescale 1ns/1ps
`include "sarcv_consts.svh"
module sarcv_host #(
  parameter int W      = `SARCV_RES_W,
  parameter int CLK_NS = 4,
  parameter int DIV    = 8
) (
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic         startReq,
  input  wire logic         serialMode,
  input  wire logic         swapBytes,
  input  wire logic         offsetBin,
  input  wire logic         sleepReq,
  sarcv_link_if.host        link,
  output logic [W-1:0]      resultWord,
  output logic              resultValid,
  output logic              hostBusy
);
  localparam int HI_CYC  = (`SARCV_STROBE_HI_NS + CLK_NS - 1) / CLK_NS;
  localparam int LO_CYC  = (`SARCV_STROBE_LO_NS / CLK_NS) < 1 ? 1 : `SARCV_STROBE_LO_NS / CLK_NS;
  localparam int ACQ_CYC = (`SARCV_ACQ_NS + CLK_NS - 1) / CLK_NS;
  localparam int RD_CYC  = `SARCV_READ_NS / CLK_NS;
  initial if (DIV < 2 || DIV * CLK_NS > `SARCV_SHIFT_MAX_NS) $error("bad shift divider");
  initial if (RD_CYC >= 1024 || ACQ_CYC >= 1024 || HI_CYC >= 1024) $error("count too wide");

  typedef struct packed {
    sarcv_pkg::sarcv_host_t st;
    logic [9:0]             cnt;
    logic [4:0]             bits;
    logic                   strobeN;
    logic                   cs;
    logic                   sclk;
    logic [W-1:0]           rx;
    logic [W-1:0]           res;
    logic                   valid;
    logic                   sd;
    logic                   devRst;
  } sarcv_host_st_t;
  sarcv_host_st_t cur_ff, nxt_cur;
  logic [W+1:0] syncIn;
  logic         busyS;
  logic         serS;
  logic [W-1:0] dataS;

  sarcv_sync #(.W(W + 2)) uSync (
    .clk  (mclk),
    .rst  (rst),
    .din  ({link.busy, link.serial_out_line, link.dataOut}),
    .dout (syncIn)
  );
  assign {busyS, serS, dataS} = syncIn;

  always_comb begin
    nxt_cur       = cur_ff;
    nxt_cur.valid = 1'b0;
    nxt_cur.sd    = sleepReq;
    nxt_cur.devRst = 1'b0;
    case (cur_ff.st)
      sarcv_pkg::HS_IDLE: begin
        nxt_cur.cnt = cur_ff.cnt + 1'b1;
        if (startReq && !sleepReq && cur_ff.cnt >= 10'(ACQ_CYC)) begin
          nxt_cur.st = sarcv_pkg::HS_HIGH;
          nxt_cur.strobeN = 1'b1;
          nxt_cur.cnt = '0;
        end
      end
      sarcv_pkg::HS_HIGH: begin
        nxt_cur.cnt = cur_ff.cnt + 1'b1;
        if (cur_ff.cnt == 10'(HI_CYC)) begin
          nxt_cur.strobeN = 1'b0;
          nxt_cur.cnt = '0;
          nxt_cur.st = sarcv_pkg::HS_LOW;
        end
      end
      sarcv_pkg::HS_LOW: begin
        nxt_cur.cnt = cur_ff.cnt + 1'b1;
        if (busyS) nxt_cur.st = sarcv_pkg::HS_WAIT;
      end
      sarcv_pkg::HS_WAIT: if (!busyS) begin
        nxt_cur.cs  = 1'b1;
        nxt_cur.cnt = '0;
        nxt_cur.bits = '0;
        nxt_cur.st  = serialMode ? sarcv_pkg::HS_SHIFT : sarcv_pkg::HS_READ;
      end
      sarcv_pkg::HS_READ: begin
        nxt_cur.cnt = cur_ff.cnt + 1'b1;
        if (cur_ff.cnt == 10'(RD_CYC)) begin
          nxt_cur.res = dataS;
          nxt_cur.st  = sarcv_pkg::HS_DONE;
        end
      end
      sarcv_pkg::HS_SHIFT: begin
        nxt_cur.cnt = cur_ff.cnt + 1'b1;
        if (cur_ff.cnt == 10'(DIV / 2 - 1)) begin
          nxt_cur.cnt  = '0;
          nxt_cur.sclk = ~cur_ff.sclk;
          if (cur_ff.sclk) begin
            nxt_cur.rx   = {cur_ff.rx[W-2:0], serS};
            nxt_cur.bits = cur_ff.bits + 1'b1;
            if (cur_ff.bits == 5'(W - 1)) begin
              nxt_cur.res = {cur_ff.rx[W-2:0], serS};
              nxt_cur.st  = sarcv_pkg::HS_DONE;
            end
          end
        end
      end
      sarcv_pkg::HS_DONE: begin
        nxt_cur.cs    = 1'b0;
        nxt_cur.sclk  = 1'b0;
        nxt_cur.valid = 1'b1;
        nxt_cur.cnt   = 10'(ACQ_CYC);
        nxt_cur.st    = sarcv_pkg::HS_IDLE;
      end
      default: nxt_cur.st = sarcv_pkg::HS_IDLE;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cur_ff         <= '0;
      cur_ff.strobeN <= 1'b1;
      cur_ff.devRst  <= 1'b1;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign link.convert_strobe_n   = cur_ff.strobeN;
  assign link.shutdown_request   = cur_ff.sd;
  assign link.resetPin           = cur_ff.devRst;
  assign link.csN                = ~cur_ff.cs;
  assign link.rdN                = ~cur_ff.cs;
  assign link.interface_select   = serialMode;
  assign link.byte_order_select  = swapBytes;
  assign link.code_format_select = offsetBin;
  assign link.shiftClk           = cur_ff.sclk;
  assign link.chain_in_line      = 1'b0;
  assign resultWord              = cur_ff.res;
  assign resultValid             = cur_ff.valid;
  assign hostBusy                = cur_ff.st != sarcv_pkg::HS_IDLE;
endmodule : sarcv_host

/* File: sarcv_link_assertions.sv */
// Concurrent checks on the converter link pins
`timescale 1ns/1ps
module sarcv_link_assertions (
  input wire logic        devClk,
  input wire logic        resetPin,
  input wire logic        convert_strobe_n,
  input wire logic        shutdown_request,
  input wire logic        csN,
  input wire logic        rdN,
  input wire logic        interface_select,
  input wire logic        busy,
  input wire logic [15:0] dataOeN,
  input wire logic        serialOeN
);
  logic [4:0] busyCnt_ff;
  logic [4:0] idleCnt_ff;

  // Busy length and quiet time before a start, in link cycles
  always_ff @(posedge devClk or posedge resetPin) begin
    if (resetPin) begin
      busyCnt_ff <= 5'h00;
      idleCnt_ff <= 5'h00;
    end else begin
      busyCnt_ff <= busy ? busyCnt_ff + 5'h01 : 5'h00;
      idleCnt_ff <= busy ? 5'h00 : ((idleCnt_ff == 5'h1F) ? idleCnt_ff : idleCnt_ff + 5'h01);
    end
  end

  default clocking cb @(posedge devClk); endclocking
  default disable iff (resetPin);

  a_float_deselected: assert property ((csN || rdN)[*4] |-> (&dataOeN) && serialOeN)
    else $error("outputs driven while deselected");
  a_bus_quiet_serial: assert property (interface_select[*4] |-> &dataOeN)
    else $error("parallel bus driven in serial mode");
  a_serial_quiet_par: assert property ((!interface_select)[*4] |-> serialOeN)
    else $error("serial line driven in parallel mode");
  a_start_raises_busy: assert property ($fell(convert_strobe_n) && !busy && !shutdown_request && idleCnt_ff >= 5'h0A
    |-> ##[1:6] busy)
    else $error("start edge not answered by busy");
  a_conv_time_max: assert property (busy |-> busyCnt_ff < 5'h0F)
    else $error("conversion longer than allowed");
  a_busy_min_hold: assert property ($rose(busy) |-> busy[*8])
    else $error("busy dropped early");
  a_conv_full_len: assert property ($fell(busy) |-> busyCnt_ff == 5'h0F)
    else $error("conversion cut short");
  a_shutdown_blocks: assert property (shutdown_request[*6] ##0 !busy |=> !busy)
    else $error("conversion started in shutdown");
  a_reset_floats: assert property (disable iff (1'b0) resetPin |-> (&dataOeN) && serialOeN && !busy)
    else $error("outputs active in reset");

  c_conv_done: cover property ($fell(busy));
  c_par_read: cover property (!(&dataOeN));
  c_ser_read: cover property (!serialOeN);
  c_sd_in_conv: cover property (shutdown_request && busy);
endmodule : sarcv_link_assertions

/* File: sarcv_tb_top.sv */
// Self-checking bench joining host and converter ends
`timescale 1ns/1ps
`define SARCV_CHK(got, exp, what) \
  comparisons++; \
  if ((got) !== (exp)) begin \
    numErrors++; \
    $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp); \
  end
module sarcv_tb_top;
  logic        mclk;
  logic        devClk;
  logic        rst;
  logic        startReq;
  logic        serialMode;
  logic        swapBytes;
  logic        offsetBin;
  logic        sleepReq;
  logic [15:0] sampleCode;
  logic [15:0] resultWord;
  logic        resultValid;
  logic        hostBusy;
  int          numErrors;
  int          comparisons;
  int          cycles;
  logic [15:0] codes [8];

  sarcv_link_if link ();

  sarcv_device i_sarcv_device (.devClk(devClk), .link(link), .sampleCode(sampleCode));

  sarcv_host i_sarcv_host (
    .mclk(mclk), .rst(rst), .startReq(startReq), .serialMode(serialMode), .swapBytes(swapBytes),
    .offsetBin(offsetBin), .sleepReq(sleepReq), .link(link), .resultWord(resultWord),
    .resultValid(resultValid), .hostBusy(hostBusy)
  );

  sarcv_link_assertions i_sarcv_link_assertions (
    .devClk(devClk), .resetPin(link.resetPin), .convert_strobe_n(link.convert_strobe_n),
    .shutdown_request(link.shutdown_request), .csN(link.csN), .rdN(link.rdN),
    .interface_select(link.interface_select), .busy(link.busy), .dataOeN(link.dataOeN),
    .serialOeN(link.serialOeN)
  );

  always #2 mclk = ~mclk;

  // Link clock offset so its edges never meet the system clock edges
  initial begin
    devClk = 1'b0;
    #1.3;
    forever #80 devClk = ~devClk;
  end

  task automatic closeOut;
    $display("Comparisons %0d, mismatches %0d", comparisons, numErrors);
    if (numErrors == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : closeOut

  // One conversion and readout; mode is serial, swap, offset binary
  task automatic runConv(input logic [15:0] code, input logic [2:0] mode, input logic sdMid);
    logic [15:0] fmt;
    logic [15:0] expWord;
    int          n;
    fmt     = mode[0] ? code : {~code[15], code[14:0]};
    expWord = (mode[1] && !mode[2]) ? {fmt[7:0], fmt[15:8]} : fmt;
    @(negedge mclk);
    sampleCode = code;
    serialMode = mode[2];
    swapBytes  = mode[1];
    offsetBin  = mode[0];
    startReq   = 1'b1;
    n = 0;
    while (link.busy !== 1'b1 && n < 3000) begin
      @(negedge mclk);
      n++;
    end
    startReq = 1'b0;
    if (sdMid) sleepReq = 1'b1;
    n = 0;
    while (resultValid !== 1'b1 && n < 3000) begin
      @(negedge mclk);
      n++;
    end
    `SARCV_CHK(n < 3000, 1'b1, "result handshake")
    `SARCV_CHK(resultWord, expWord, "result word")
    repeat (300) @(negedge mclk);
    sleepReq = 1'b0;
    `SARCV_CHK({link.dataOeN, link.serialOeN}, 17'h1_FFFF, "outputs after read")
  endtask : runConv

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 40000) begin
      numErrors++;
      $display("unexpected at %0t: run did not finish", $time);
      closeOut();
    end
  end

  initial begin
    mclk        = 1'b0;
    rst         = 1'b1;
    startReq    = 1'b0;
    serialMode  = 1'b0;
    swapBytes   = 1'b0;
    offsetBin   = 1'b0;
    sleepReq    = 1'b0;
    sampleCode  = 16'h0000;
    numErrors   = 0;
    comparisons = 0;
    cycles      = 0;
    codes = '{16'h1234, 16'h8001, 16'hFFFF, 16'h0000, 16'hA5C3, 16'h7FFE, 16'h5A3C, 16'hC0DE};
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    rst = 1'b0;
    for (int i = 0; i < 8; i++) begin
      runConv(codes[i], 3'(i), 1'b0);
    end
    runConv(16'h9ABC, 3'h1, 1'b1);
    runConv(16'h3C5A, 3'h4, 1'b0);
    closeOut();
  end
endmodule : sarcv_tb_top
